/* File: hw/dat_pkg.sv */
// Purpose: shared constants for the dual autoreload timer trip and status block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes: all offsets, field positions, the trip enable and counter reset values, and timing counts live here
package dat_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [ADDR_W-1:0] CS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CNT_LO_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CNT_HI_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] TC_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] TE_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] RL1_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] RL2_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] PC_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] DUTY0_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] DUTY_STEP = 8'h04;
  localparam logic [ADDR_W-1:0] CAP_LO_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] CAP_HI_OFS = 8'h34;
  localparam logic [ADDR_W-1:0] CMP_OFS = 8'h38;
  // timer_ctrl_status fields
  localparam int CS_CAP_FLAG = 6;
  localparam int CS_CAP_IE = 5;
  localparam int CS_CLK_LSB = 3;
  localparam int CS_WRAP_FLAG = 2;
  localparam int CS_WRAP_IE = 1;
  localparam int CS_CMP_IE = 0;
  // trip_control_reg fields
  localparam int TC_SRC = 7;
  localparam int TC_POL = 6;
  localparam int TC_ACT = 5;
  localparam int TC_FEN = 4;
  // trip_enable_reg fields and reset
  localparam int TE_EN1 = 0;
  localparam int TE_EN2 = 1;
  localparam logic [1:0] TE_RESET = 2'h3;
  // pulse_control_reg fields
  localparam int PC_W = 9;
  localparam int PC_OE_LSB = 0;
  localparam int PC_INV_LSB = 4;
  localparam int PC_DUAL = 8;
  // counters and channels
  localparam int CNT_W = 12;
  localparam int NCH = 4;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
  // counter clock select codes
  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_TIMEBASE = 2'b01,
    CLK_CPU = 2'b10,
    CLK_FAST = 2'b11
  } dat_clk_sel_type;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TB_PERIOD_NS = 1000000;
  localparam int TB_CYCLES = (TB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: hw/dat_trip_if.sv */
// Purpose: carrier between the timer top and the trip latch
// Assumes: one clock domain, all signals sampled on mclk_i
// Notes: the top drives configuration and software strobes, the latch answers with active
`timescale 1ns/100ps
`default_nettype none
interface dat_trip_if;
  logic pin;
  logic comparator;
  logic source_sel;
  logic polarity;
  logic fn_en;
  logic sw_set;
  logic sw_clear;
  logic active;
  modport ctl (output pin, comparator, source_sel, polarity, fn_en, sw_set, sw_clear,
               input active);
  modport trip (input pin, comparator, source_sel, polarity, fn_en, sw_set, sw_clear,
                output active);
endinterface
`default_nettype wire

/* File: hw/dat_trip.sv */
// Purpose: trip source selection, level qualification and the sticky active latch
// Assumes: trip pin and comparator are synchronous to mclk_i
// Notes: a hardware trip in the same cycle as a software clear keeps the latch set
`timescale 1ns/100ps
`default_nettype none
module dat_trip (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // link to the timer top
  dat_trip_if.trip tr
);
  logic active_q;
  logic active_d;
  logic trigger;
  logic hw_set;

  // pick the source, compare with the programmed level, then latch
  always_comb begin
    trigger = ((tr.source_sel ? tr.comparator : tr.pin) == tr.polarity); // [R1] [R3]
    hw_set = tr.fn_en & trigger; // [R2]
    active_d = active_q & ~tr.sw_clear; // [R12] [R21]
    if (hw_set || (tr.fn_en && tr.sw_set)) begin // [R4] [R5]
      active_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  assign tr.active = active_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_trip_hold_level: assert property (active_q && !tr.sw_clear |=> active_q) // [R21]
    else $error("trip latch dropped without a software clear");
  a_trip_needs_enable: assert property (!tr.fn_en && !active_q |=> !active_q) // [R2]
    else $error("trip latched while the function was disabled");
  a_trip_level_sets: assert property (tr.fn_en && trigger |=> active_q [*2] or // [R4]
                                      (active_q ##1 $past(tr.sw_clear)))
    else $error("active trip level did not set the latch");
  a_trip_sw_sets: assert property (tr.fn_en && tr.sw_set |=> active_q) // [R5]
    else $error("software set did not activate the trip");
endmodule // dat_trip
`default_nettype wire

/* File: hw/dat_timer_top.sv */
// Purpose: dual 12-bit autoreload timer with trip shutdown and control/status register
// Assumes: all inputs synchronous to mclk_i; 8-bit registers sit in the low bits of a word
// Notes: the fast counter clock cannot exceed mclk_i here, so it steps once per cycle
// Operation
// [R1] trip comes from the pin or the comparator, chosen by the source select bit
// [R2] software enables the trip function; while disabled no trip activates
// [R3] the trip level is set by the polarity bit
// [R4] seeing the active level sets the trip active flag and enters trip state
// [R5] a software write of one to the active flag trips exactly like hardware
// [R6] dual mode: counter two enable governs channels two and three, counter one the rest
// [R7] single mode: counter one enable alone governs every channel
// [R8] tripped enabled outputs take the pattern bits, after the output inverter
// [R9] a trip clears the first counter when its enable is set
// [R10] a trip clears the second counter when its enable is set
// [R11] a trip resets reloads and duty values and stops both counters
// [R12] software clearing the active flag returns outputs to the timer
// [R13] capture flag set on capture, cleared by reading capture bytes, writes ignored
// [R14] capture irq enable gates the capture request
// [R15] clock select: off, 1 ms timebase, cpu clock, fast clock; cleared at reset
// [R16] wrap flag set on FFFh to reload, cleared by reading control/status
// [R17] wrap irq enable is read/write, reset clear, gates the wrap request
// [R18] compare irq enable masks the request raised by any compare flag
// [R19] first counter runs once a clock is chosen; read as low then high byte
// [R20] on wrap the first counter restarts from its reload value
// [R21] trip active stays set until software writes zero
// [R22] counter high byte gives bits 11..8, upper nibble zero, writes ignored
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module dat_timer_top #(
  parameter int TB_CYCLES_P = dat_pkg::TB_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [dat_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [dat_pkg::DATA_W-1:0] avs_writedata_i,
  output logic [dat_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // trip sources and capture input
  input wire logic trip_pin_i,
  input wire logic comparator_i,
  input wire logic capture_i,
  // pulse outputs to the power stage
  output logic [dat_pkg::NCH-1:0] pulse_output_o,
  output logic [dat_pkg::NCH-1:0] pulse_output_en_o,
  // interrupt requests and trip state
  output logic capture_irq_o,
  output logic wrap_irq_o,
  output logic compare_irq_o,
  output logic trip_active_o
);
  import dat_pkg::*;

  localparam int TBW = $clog2(TB_CYCLES_P + 1);
  typedef enum logic {BUS_IDLE, BUS_ACK} dat_bus_type;

  dat_bus_type bus_q, bus_d;
  logic wait_q, wait_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic cap_flag_q, cap_flag_d, cap_ie_q, cap_ie_d;
  dat_clk_sel_type clk_sel_q, clk_sel_d;
  logic wrap_flag_q, wrap_flag_d, wrap_ie_q, wrap_ie_d, cmp_ie_q, cmp_ie_d;
  logic src_q, src_d, pol_q, pol_d, fen_q, fen_d;
  logic [NCH-1:0] pattern_q, pattern_d;
  logic [1:0] te_q, te_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [CNT_W-1:0] reload1_q, reload1_d, reload2_q, reload2_d;
  logic [CNT_W-1:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d, cap_val_q, cap_val_d;
  logic [CNT_W-1:0] duty_pre_q [NCH];
  logic [CNT_W-1:0] duty_pre_d [NCH];
  logic [CNT_W-1:0] duty_act_q [NCH];
  logic [CNT_W-1:0] duty_act_d [NCH];
  logic [NCH-1:0] cmp_flag_q, cmp_flag_d, out_q, out_d, oe_q, oe_d;
  logic [TBW-1:0] tb_cnt_q, tb_cnt_d;
  logic cap_in_q;
  logic cap_irq_q, cap_irq_d, wrap_irq_q, wrap_irq_d, cmp_irq_q, cmp_irq_d;
  logic acc, wr_acc, rd_acc, tick, run, run2, wrap1, wrap2, dual, cap_rise;

  dat_trip_if tr ();

  // address decode, shared by the read mux and every write strobe
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // merge write data into a 16-bit field honouring the two low byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // channel counter: upper pair follow counter two only in dual mode
  function automatic logic [CNT_W-1:0] ch_cnt(input int i, input logic dm,
                                              input logic [CNT_W-1:0] c1,
                                              input logic [CNT_W-1:0] c2);
    return (dm && i >= 2) ? c2 : c1;
  endfunction

  // trip latch configuration and software strobes
  assign tr.pin = trip_pin_i;
  assign tr.comparator = comparator_i;
  assign tr.source_sel = src_q;
  assign tr.polarity = pol_q;
  assign tr.fn_en = fen_q;
  assign tr.sw_set = wr_acc & hit(avs_address_i, TC_OFS) & avs_byteenable_i[0]
                     & avs_writedata_i[TC_ACT];
  assign tr.sw_clear = wr_acc & hit(avs_address_i, TC_OFS) & avs_byteenable_i[0]
                       & ~avs_writedata_i[TC_ACT];

  dat_trip u_trip (
    .mclk_i (mclk_i),
    .rst_i (rst_i),
    .tr (tr.trip)
  );

  // bus handshake: one wait cycle, then the transfer is accepted
  always_comb begin
    acc = (bus_q == BUS_ACK);
    wr_acc = acc & avs_write_i;
    rd_acc = acc & avs_read_i;
    bus_d = bus_q;
    wait_d = 1'b1;
    case (bus_q)
      BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          bus_d = BUS_ACK;
          wait_d = 1'b0;
        end
      end
      BUS_ACK: bus_d = BUS_IDLE;
      default: bus_d = BUS_IDLE;
    endcase
  end

  // read mux, sampled in the wait cycle so data stand at the accept edge
  always_comb begin
    rdata_d = rdata_q;
    if (bus_q == BUS_IDLE && avs_read_i) begin
      rdata_d = '0;
      case (avs_address_i)
        CS_OFS: rdata_d[7:0] = {1'b0, cap_flag_q, cap_ie_q, clk_sel_q, wrap_flag_q,
                                wrap_ie_q, cmp_ie_q};
        CNT_LO_OFS: rdata_d[7:0] = cnt1_q[7:0]; // [R19]
        CNT_HI_OFS: rdata_d[7:0] = {4'h0, cnt1_q[11:8]}; // [R22]
        TC_OFS: rdata_d[7:0] = {src_q, pol_q, tr.active, fen_q, pattern_q};
        TE_OFS: rdata_d[1:0] = te_q;
        RL1_OFS: rdata_d[CNT_W-1:0] = reload1_q;
        RL2_OFS: rdata_d[CNT_W-1:0] = reload2_q;
        PC_OFS: rdata_d[PC_W-1:0] = pc_q;
        CAP_LO_OFS: rdata_d[7:0] = cap_val_q[7:0];
        CAP_HI_OFS: rdata_d[7:0] = {4'h0, cap_val_q[11:8]};
        CMP_OFS: rdata_d[NCH-1:0] = cmp_flag_q;
        default: rdata_d = '0; // unmapped reads return zero
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (hit(avs_address_i, DUTY0_OFS + ADDR_W'(i) * DUTY_STEP)) begin
          rdata_d[CNT_W-1:0] = duty_pre_q[i];
        end
      end
    end
  end

  // configuration registers written by software
  always_comb begin
    cap_ie_d = cap_ie_q;
    clk_sel_d = clk_sel_q;
    wrap_ie_d = wrap_ie_q;
    cmp_ie_d = cmp_ie_q;
    src_d = src_q;
    pol_d = pol_q;
    fen_d = fen_q;
    pattern_d = pattern_q;
    te_d = te_q;
    pc_d = pc_q;
    if (wr_acc && avs_byteenable_i[0]) begin
      if (hit(avs_address_i, CS_OFS)) begin
        cap_ie_d = avs_writedata_i[CS_CAP_IE]; // [R14]
        clk_sel_d = dat_clk_sel_type'(avs_writedata_i[CS_CLK_LSB +: 2]); // [R15]
        wrap_ie_d = avs_writedata_i[CS_WRAP_IE]; // [R17]
        cmp_ie_d = avs_writedata_i[CS_CMP_IE]; // [R18]
      end
      if (hit(avs_address_i, TC_OFS)) begin
        src_d = avs_writedata_i[TC_SRC];
        pol_d = avs_writedata_i[TC_POL];
        fen_d = avs_writedata_i[TC_FEN];
        pattern_d = avs_writedata_i[NCH-1:0];
      end
      if (hit(avs_address_i, TE_OFS)) begin
        te_d = avs_writedata_i[1:0];
      end
    end
    if (wr_acc && hit(avs_address_i, PC_OFS)) begin
      pc_d = PC_W'(merge16({{(16 - PC_W){1'b0}}, pc_q}, avs_writedata_i[15:0],
                           avs_byteenable_i[1:0]));
    end
  end

  // counter datapath: clock select, wrap, capture, compare, trip override
  always_comb begin
    dual = pc_q[PC_DUAL];
    tb_cnt_d = (tb_cnt_q == TBW'(TB_CYCLES_P - 1)) ? '0 : tb_cnt_q + TBW'(1);
    case (clk_sel_q) // [R15]
      CLK_OFF: tick = 1'b0;
      CLK_TIMEBASE: tick = (tb_cnt_q == TBW'(TB_CYCLES_P - 1));
      CLK_CPU: tick = 1'b1;
      CLK_FAST: tick = 1'b1;
      default: tick = 1'b0;
    endcase
    run = tick & ~tr.active; // [R11]
    run2 = run & dual;
    wrap1 = run & (cnt1_q == CNT_MAX);
    wrap2 = run2 & (cnt2_q == CNT_MAX);
    cap_rise = capture_i & ~cap_in_q;
    reload1_d = reload1_q;
    reload2_d = reload2_q;
    duty_pre_d = duty_pre_q;
    duty_act_d = duty_act_q;
    if (wr_acc && hit(avs_address_i, RL1_OFS)) begin
      reload1_d = CNT_W'(merge16({4'h0, reload1_q}, avs_writedata_i[15:0],
                                 avs_byteenable_i[1:0]));
    end
    if (wr_acc && hit(avs_address_i, RL2_OFS)) begin
      reload2_d = CNT_W'(merge16({4'h0, reload2_q}, avs_writedata_i[15:0],
                                 avs_byteenable_i[1:0]));
    end
    for (int i = 0; i < NCH; i++) begin
      if (wr_acc && hit(avs_address_i, DUTY0_OFS + ADDR_W'(i) * DUTY_STEP)) begin
        duty_pre_d[i] = CNT_W'(merge16({4'h0, duty_pre_q[i]}, avs_writedata_i[15:0],
                                       avs_byteenable_i[1:0]));
      end
      if ((dual && i >= 2) ? wrap2 : wrap1) begin
        duty_act_d[i] = duty_pre_q[i];
      end
    end
    cnt1_d = cnt1_q;
    if (run) begin
      cnt1_d = wrap1 ? reload1_q : cnt1_q + CNT_W'(1); // [R19] [R20]
    end
    cnt2_d = cnt2_q;
    if (run2) begin
      cnt2_d = wrap2 ? reload2_q : cnt2_q + CNT_W'(1);
    end
    // sticky flags: a set in the clearing cycle wins
    wrap_flag_d = wrap_flag_q & ~(rd_acc & hit(avs_address_i, CS_OFS));
    if (wrap1) begin
      wrap_flag_d = 1'b1; // [R16]
    end
    cap_flag_d = cap_flag_q & ~(rd_acc & (hit(avs_address_i, CAP_LO_OFS)
                                          | hit(avs_address_i, CAP_HI_OFS))); // [R13]
    cap_val_d = cap_val_q;
    if (cap_rise) begin
      cap_flag_d = 1'b1;
      cap_val_d = cnt1_q;
    end
    cmp_flag_d = cmp_flag_q & ~{NCH{rd_acc & hit(avs_address_i, CMP_OFS)}};
    for (int i = 0; i < NCH; i++) begin
      if (((dual && i >= 2) ? run2 : run) &&
          ch_cnt(i, dual, cnt1_q, cnt2_q) == duty_act_q[i]) begin
        cmp_flag_d[i] = 1'b1;
      end
    end
    // trip state holds reloads, duties and enabled counters at reset value
    if (tr.active) begin
      reload1_d = CNT_RESET; // [R11]
      reload2_d = CNT_RESET;
      for (int i = 0; i < NCH; i++) begin
        duty_pre_d[i] = CNT_RESET;
        duty_act_d[i] = CNT_RESET;
      end
      if (te_q[TE_EN1]) begin
        cnt1_d = CNT_RESET; // [R9]
      end
      if (te_q[TE_EN2]) begin
        cnt2_d = CNT_RESET; // [R10]
      end
    end
  end

  // pulse outputs and gated requests, all registered
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      logic applied;
      logic level;
      applied = tr.active & ((dual && i >= 2) ? te_q[TE_EN2] : te_q[TE_EN1]); // [R6] [R7]
      level = (ch_cnt(i, dual, cnt1_q, cnt2_q) < duty_act_q[i]) ^ pc_q[PC_INV_LSB + i];
      out_d[i] = pc_q[PC_OE_LSB + i] & (applied ? pattern_q[i] : level); // [R8] [R12]
      oe_d[i] = pc_q[PC_OE_LSB + i];
    end
    cap_irq_d = cap_flag_q & cap_ie_q; // [R14]
    wrap_irq_d = wrap_flag_q & wrap_ie_q; // [R17]
    cmp_irq_d = (|cmp_flag_q) & cmp_ie_q; // [R18]
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
      cap_flag_q <= 1'b0;
      cap_ie_q <= 1'b0;
      clk_sel_q <= CLK_OFF;
      wrap_flag_q <= 1'b0;
      wrap_ie_q <= 1'b0;
      cmp_ie_q <= 1'b0;
      src_q <= 1'b0;
      pol_q <= 1'b0;
      fen_q <= 1'b0;
      pattern_q <= '0;
      te_q <= TE_RESET;
      pc_q <= '0;
      reload1_q <= CNT_RESET;
      reload2_q <= CNT_RESET;
      cnt1_q <= CNT_RESET;
      cnt2_q <= CNT_RESET;
      cap_val_q <= CNT_RESET;
      for (int i = 0; i < NCH; i++) begin
        duty_pre_q[i] <= CNT_RESET;
        duty_act_q[i] <= CNT_RESET;
      end
      cmp_flag_q <= '0;
      out_q <= '0;
      oe_q <= '0;
      tb_cnt_q <= '0;
      cap_in_q <= 1'b0;
      cap_irq_q <= 1'b0;
      wrap_irq_q <= 1'b0;
      cmp_irq_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      cap_flag_q <= cap_flag_d;
      cap_ie_q <= cap_ie_d;
      clk_sel_q <= clk_sel_d;
      wrap_flag_q <= wrap_flag_d;
      wrap_ie_q <= wrap_ie_d;
      cmp_ie_q <= cmp_ie_d;
      src_q <= src_d;
      pol_q <= pol_d;
      fen_q <= fen_d;
      pattern_q <= pattern_d;
      te_q <= te_d;
      pc_q <= pc_d;
      reload1_q <= reload1_d;
      reload2_q <= reload2_d;
      cnt1_q <= cnt1_d;
      cnt2_q <= cnt2_d;
      cap_val_q <= cap_val_d;
      duty_pre_q <= duty_pre_d;
      duty_act_q <= duty_act_d;
      cmp_flag_q <= cmp_flag_d;
      out_q <= out_d;
      oe_q <= oe_d;
      tb_cnt_q <= tb_cnt_d;
      cap_in_q <= capture_i;
      cap_irq_q <= cap_irq_d;
      wrap_irq_q <= wrap_irq_d;
      cmp_irq_q <= cmp_irq_d;
    end
  end

  // trip_active_o lags the latch by one cycle to come from a flop
  logic trip_out_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      trip_out_q <= 1'b0;
    end else begin
      trip_out_q <= tr.active;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign pulse_output_o = out_q;
  assign pulse_output_en_o = oe_q;
  assign capture_irq_o = cap_irq_q;
  assign wrap_irq_o = wrap_irq_q;
  assign compare_irq_o = cmp_irq_q;
  assign trip_active_o = trip_out_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && bus_q == BUS_IDLE;
  endsequence
  sequence s_wrap_edge;
    run && cnt1_q == CNT_MAX;
  endsequence

  a_bus_one_wait: assert property (s_bus_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus accept not exactly one cycle after request");
  a_wrap_reload: assert property (s_wrap_edge |=> cnt1_q == $past(reload1_q)) // [R20]
    else $error("counter did not restart from reload value");
  a_wrap_flag_set: assert property (s_wrap_edge |=> wrap_flag_q) // [R16]
    else $error("wrap flag not set on wrap");
  a_trip_clear_cnt: assert property (tr.active && te_q[TE_EN1] |=> cnt1_q == CNT_RESET) // [R9]
    else $error("first counter not cleared in trip state");
  a_trip_reload_rst: assert property (tr.active |=> reload2_q == CNT_RESET) // [R11]
    else $error("reload not reset in trip state");
  a_trip_pattern_out: assert property (tr.active && te_q[TE_EN1] && !pc_q[PC_DUAL] && // [R8]
                                       pc_q[PC_OE_LSB] |=> pulse_output_o[0] ==
                                       $past(pattern_q[0]))
    else $error("tripped output does not show pattern");
  a_clock_off_hold: assert property (clk_sel_q == CLK_OFF && !tr.active |=> // [R15]
                                     $stable(cnt1_q))
    else $error("counter moved with clock off");
  a_capture_flag: assert property (capture_i && !cap_in_q |=> cap_flag_q) // [R13]
    else $error("capture flag not set on capture");
  a_wrap_irq_mask: assert property (!wrap_ie_q [*2] |-> !wrap_irq_o) // [R17]
    else $error("wrap request raised while masked");
  a_hi_nibble_zero: assert property (!avs_waitrequest_o && avs_read_i && // [R22]
                                     avs_address_i == CNT_HI_OFS |-> avs_readdata_o[31:4] == '0)
    else $error("counter high byte upper bits not zero");
endmodule // dat_timer_top
`default_nettype wire

/* File: bench/dat_far_side.sv */
// Purpose: trip sources and power stage seen from the timer
// Assumes: bench levels change just after a rising edge
// Notes: a leg whose enable is low is pulled down in the stage
`timescale 1ns/100ps
`default_nettype none
module dat_far_side (
  // clock and commanded levels
  input wire logic mclk_i,
  input wire logic pin_lvl_i,
  input wire logic cmp_lvl_i,
  // pulse outputs
  input wire logic [3:0] pwm_i,
  input wire logic [3:0] pwm_en_i,
  // trip sources and stage view
  output logic trip_pin_o,
  output logic comparator_o,
  output logic [3:0] stage_o
);
  // sources settle one edge later, like a synchronised pin
  always @(posedge mclk_i) begin
    trip_pin_o <= pin_lvl_i;
    comparator_o <= cmp_lvl_i;
  end
  // undriven legs read low
  assign stage_o = pwm_i & pwm_en_i;
endmodule // dat_far_side
`default_nettype wire

/* File: bench/test_dat_timer_top.sv */
// Purpose: self-checking bench for the timer trip and status block
// Assumes: timebase shortened to 8 cycles; transfers wait for waitrequest low
// Notes: pattern and status values come from an lfsr
`timescale 1ns/100ps
`default_nettype none
module test_dat_timer_top;
  import dat_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd = 1'b0, wr = 1'b0, pin = 1'b0, cmp = 1'b0, cap = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q, q0, seed = 32'hfca2d497;
  logic wreq, tpin, comp, cap_irq, act, wirq, cirq;
  logic [3:0] pwm, pwm_en, stage;
  int n_mismatch = 0;
  int n_tests = 0;
  dat_timer_top #(.TB_CYCLES_P(8)) dat_timer_top_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'hf), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .trip_pin_i(tpin),
    .comparator_i(comp), .capture_i(cap), .pulse_output_o(pwm),
    .pulse_output_en_o(pwm_en), .capture_irq_o(cap_irq), .wrap_irq_o(wirq),
    .compare_irq_o(cirq), .trip_active_o(act));
  dat_far_side dat_far_side_i (.mclk_i(mclk_i), .pin_lvl_i(pin), .cmp_lvl_i(cmp),
    .pwm_i(pwm), .pwm_en_i(pwm_en), .trip_pin_o(tpin), .comparator_o(comp),
    .stage_o(stage));
  // free running clock
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // tripped channels take the pattern, the rest idle high with inverters set
  function automatic logic [3:0] exp_pwm(input logic dual, input logic [1:0] en);
    return dual ? {~en[1], ~en[1], ~en[0], ~en[0]} : {4{~en[0]}};
  endfunction
  // low byte advance over 83 cycles for each clock code
  function automatic logic rate_ok(input int c, input logic [7:0] d);
    if (c == 0) return d == 8'h00;
    if (c == 1) return d >= 8'h08 && d <= 8'h0d;
    return d >= 8'h50 && d <= 8'h5f;
  endfunction
  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one transfer, held until waitrequest is sampled low
  // a hang is caught by the watchdog, not here
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk_i);
    while (wreq !== 1'b0) begin
      @(posedge mclk_i);
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // watchdog sized well above the longest sequence
  initial begin
    repeat (12000) @(posedge mclk_i);
    n_mismatch++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(CS_OFS, 32'h0);
    rchk(TE_OFS, 32'h3);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'b1, CS_OFS, seed);
      rchk(CS_OFS, seed & 32'h3b);
    end
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, CS_OFS, {27'h0, c[1:0], 3'h0});
      bus(1'b0, CNT_LO_OFS, 32'h0);
      q0 = q;
      repeat (80) @(posedge mclk_i);
      bus(1'b0, CNT_LO_OFS, 32'h0);
      chk(rate_ok(c, q[7:0] - q0[7:0]), 1'b1);
    end
    bus(1'b1, CS_OFS, 32'h0);
    bus(1'b1, CNT_HI_OFS, 32'hff);
    rchk(CNT_HI_OFS, 32'h0);
    bus(1'b1, PC_OFS, 32'hff);
    // each source and level: the other source at trip level must not act
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      pin <= i[1] ? i[0] : !i[0];
      cmp <= i[1] ? !i[0] : i[0];
      bus(1'b1, RL1_OFS, {20'h0, seed[15:4]});
      bus(1'b1, TC_OFS, {24'h0, i[1], i[0], 2'b01, seed[3:0]});
      repeat (6) @(posedge mclk_i);
      chk(act, 1'b0);
      pin <= i[0];
      cmp <= i[0];
      repeat (6) @(posedge mclk_i);
      chk(act, 1'b1);
      chk(stage, seed[3:0]);
      rchk(CNT_LO_OFS, 32'h0);
      rchk(RL1_OFS, 32'h0);
      pin <= i[1] ? i[0] : !i[0];
      cmp <= i[1] ? !i[0] : i[0];
      repeat (6) @(posedge mclk_i);
      chk(act, 1'b1);
      bus(1'b1, TC_OFS, 32'h0);
      repeat (4) @(posedge mclk_i);
      chk(stage, 4'hf);
    end
    cmp <= 1'b0;
    pin <= 1'b1;
    bus(1'b1, TC_OFS, 32'h60);
    repeat (6) @(posedge mclk_i);
    chk(act, 1'b0);
    pin <= 1'b0;
    // the enable must already stand before a software set can act
    bus(1'b1, TC_OFS, 32'h50);
    bus(1'b1, TC_OFS, 32'h70);
    repeat (6) @(posedge mclk_i);
    chk(act, 1'b1);
    bus(1'b1, TC_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, PC_OFS, {23'h0, i[1], 8'hff});
      bus(1'b1, TE_OFS, {30'h0, !i[0], i[0]});
      bus(1'b1, TC_OFS, 32'h50);
      bus(1'b1, TC_OFS, 32'h70);
      repeat (6) @(posedge mclk_i);
      chk(stage, exp_pwm(i[1], {!i[0], i[0]}));
      bus(1'b1, TC_OFS, 32'h0);
    end
    bus(1'b1, RL1_OFS, 32'h800);
    bus(1'b1, CS_OFS, 32'h13);
    repeat (4150) @(posedge mclk_i);
    chk(wirq, 1'b1);
    chk(cirq, 1'b1);
    rchk(CS_OFS, 32'h17);
    rchk(CS_OFS, 32'h13);
    chk(wirq, 1'b0);
    rchk(CMP_OFS, 32'hf);
    rchk(CNT_HI_OFS, 32'h08);
    chk(cirq, 1'b0);
    bus(1'b1, CS_OFS, 32'h20);
    cap <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk(cap_irq, 1'b1);
    rchk(CS_OFS, 32'h60);
    bus(1'b0, CAP_LO_OFS, 32'h0);
    rchk(CS_OFS, 32'h20);
    test_done;
  end
endmodule // test_dat_timer_top
`default_nettype wire
